// >>> inc/csc_pkg.sv
// Constants for the card-bus system control bits block.
// Assumes a 200 MHz mclk and byte offsets in configuration space.
package csc_pkg;
  localparam logic [7:0]  SC_OFFSET      = 8'h80;
  localparam logic [31:0] SC_RESET_WORD  = 32'h0800_9060;
  localparam logic [31:0] SC_OWN_MASK    = 32'h0060_FFE0;
  localparam int          B_RSVD_DRIVE   = 22;
  localparam int          B_PROT_DIS     = 21;
  localparam int          B_BURST_DN     = 15;
  localparam int          B_BURST_UP     = 14;
  localparam int          B_ACTIVITY     = 13;
  localparam int          B_ONE          = 12;
  localparam int          B_STREAM       = 11;
  localparam int          B_UP_DLY       = 10;
  localparam int          B_DOWN_DLY     = 9;
  localparam int          B_INTERROG     = 8;
  localparam int          B_ZERO         = 7;
  localparam int          B_LOW_POW      = 6;
  localparam int          B_ID_LOCK      = 5;
  localparam logic        RST_RSVD_DRIVE = 1'b1;
  localparam logic        RST_PROT_DIS   = 1'b0;
  localparam logic        RST_BURST_DN   = 1'b1;
  localparam logic        RST_BURST_UP   = 1'b0;
  localparam logic        RST_LOW_POW    = 1'b1;
  localparam logic        RST_ID_LOCK    = 1'b1;
  localparam int          CLK_MHZ        = 200;
  localparam int          PSW_BIT_NS     = 500;
  localparam int          UP_DELAY_US    = 20;
  localparam int          DOWN_DELAY_US  = 10;
  localparam int          STREAM_BITS    = 8;
  localparam int          PSW_BIT_CYC    = (PSW_BIT_NS * CLK_MHZ) / 1000;
  localparam int          UP_DELAY_CYC   = UP_DELAY_US * CLK_MHZ;
  localparam int          DOWN_DELAY_CYC = DOWN_DELAY_US * CLK_MHZ;
  typedef enum logic [1:0] {
    PS_IDLE   = 2'b00,
    PS_STREAM = 2'b01,
    PS_DELAY  = 2'b10
  } csc_pstate_e;
endpackage

// >>> inc/csc_pwr_if.sv
// Link between the register bank and the power switch sequencer.
// Assumes both ends run on the same mclk.
`timescale 1ns/10ps
interface csc_pwr_if;
  logic       powerReq;
  logic       powerUp;
  logic [7:0] powerWord;
  logic       streamBusy;
  logic       upDelayBusy;
  logic       downDelayBusy;
  modport ctrl (output powerReq, output powerUp, output powerWord,
                input streamBusy, input upDelayBusy, input downDelayBusy);
  modport seq  (input powerReq, input powerUp, input powerWord,
                output streamBusy, output upDelayBusy, output downDelayBusy);
endinterface

// >>> verilog/csc_power_seq.sv
// Power switch serial stream and settling delay sequencer.
// Assumes requests arrive as one-cycle pulses on mclk.
`timescale 1ns/10ps
module csc_power_seq #(
  parameter int BIT_CYC  = csc_pkg::PSW_BIT_CYC,
  parameter int UP_CYC   = csc_pkg::UP_DELAY_CYC,
  parameter int DOWN_CYC = csc_pkg::DOWN_DELAY_CYC
) (
  input  wire logic mclk,
  input  wire logic reset,
  csc_pwr_if.seq    pwr,
  output logic      pswData,
  output logic      pswLatch
);
  typedef struct packed {
    csc_pkg::csc_pstate_e st;
    logic [3:0]           bitCnt;
    logic [7:0]           divCnt;
    logic [12:0]          dlyCnt;
    logic [7:0]           shift;
    logic                 up;
    logic                 data;
    logic                 latch;
  } csc_seq_s;

  csc_seq_s st_reg;
  csc_seq_s st_next;
  logic     tick;

  assign tick = (st_reg.divCnt == 8'(BIT_CYC - 1));

  always_comb begin
    st_next = st_reg;
    st_next.latch = 1'b0;
    unique case (st_reg.st)
      csc_pkg::PS_IDLE: begin
        // Requests while busy are dropped, the stream is never cut short
        if (pwr.powerReq) begin
          st_next.st = csc_pkg::PS_STREAM;
          st_next.shift = pwr.powerWord;
          st_next.up = pwr.powerUp;
          st_next.bitCnt = 4'h0;
          st_next.divCnt = 8'h00;
        end
      end
      csc_pkg::PS_STREAM: begin
        st_next.divCnt = tick ? 8'h00 : st_reg.divCnt + 8'h01;
        if (tick) begin
          st_next.data = st_reg.shift[7];
          st_next.shift = {st_reg.shift[6:0], 1'b0};
          st_next.bitCnt = st_reg.bitCnt + 4'h1;
          if (st_reg.bitCnt == 4'(csc_pkg::STREAM_BITS - 1)) begin
            st_next.st = csc_pkg::PS_DELAY;
            st_next.latch = 1'b1;
            st_next.dlyCnt = st_reg.up ? 13'(UP_CYC - 1) : 13'(DOWN_CYC - 1);
          end
        end
      end
      csc_pkg::PS_DELAY: begin
        st_next.dlyCnt = st_reg.dlyCnt - 13'h0001;
        if (st_reg.dlyCnt == 13'h0000) begin
          st_next.st = csc_pkg::PS_IDLE;
        end
      end
      default: st_next.st = csc_pkg::PS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '{st: csc_pkg::PS_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwr.streamBusy    = (st_reg.st != csc_pkg::PS_IDLE);
  assign pwr.upDelayBusy   = (st_reg.st == csc_pkg::PS_DELAY) && st_reg.up;
  assign pwr.downDelayBusy = (st_reg.st == csc_pkg::PS_DELAY) && !st_reg.up;
  assign pswData  = st_reg.data;
  assign pswLatch = st_reg.latch;
endmodule

// >>> verilog/csc_sysctl.sv
// System control bits 22..5 of a dual-function card-bus controller.
// Assumes a single-cycle configuration port on mclk; reset is the global reset.
// Summary of operation
// - Bit 22 set drives reserved card terminals low once a card is inserted.
// - Bit 21 per socket; set disables supply protection for 16-bit cards.
// - Downstream memory read bursts allowed only while bit 15 is set; resets set.
// - Upstream memory read bursts allowed only while bit 14 is set; resets clear.
// - Bit 13 per socket, set by card access, cleared by a read with byte enable 1 set.
// - Bit 12 always reads one, writes ignored.
// - Bit 11 high from supply change request until stream and delay finish.
// - Bit 10 high after power-up stream sent until up delay expires.
// - Bit 9 high after power-down stream sent until down delay expires.
// - Bit 8 per socket reads one while card interrogation runs.
// - Bit 7 always reads zero, writes ignored.
// - Bit 6 shared, resets set, enables reduced consumption mode.
// - Bit 5 set makes identification registers read-only; clear allows writes.
// - These bits are cleared only by the global reset, no lesser reset.
// - Power context bits 10..8 cleared by global reset, PME enabled or not.
// - Register sits at offset 0x80 in functions 0 and 1.
`timescale 1ns/10ps
module csc_sysctl #(
  parameter int BIT_CYC  = csc_pkg::PSW_BIT_CYC,
  parameter int UP_CYC   = csc_pkg::UP_DELAY_CYC,
  parameter int DOWN_CYC = csc_pkg::DOWN_DELAY_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic        cfgFunc,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic      [31:0] cfgRdData,
  output logic             cfgRdValid,
  input  wire logic [1:0]  socketAccess,
  input  wire logic [1:0]  interrogBusy,
  input  wire logic [1:0]  cardbusInserted,
  input  wire logic        powerReq,
  input  wire logic        powerUp,
  input  wire logic [7:0]  powerWord,
  output logic             pswData,
  output logic             pswLatch,
  output logic      [1:0]  rsvdPinOut,
  output logic      [1:0]  rsvdPinOe,
  output logic      [1:0]  supplyProtectEn,
  output logic             readBurstDownstreamEn,
  output logic             readBurstUpstreamEn,
  output logic             lowConsumptionEn,
  output logic             idRegistersLock
);
  typedef struct packed {
    logic        rsvdDrive;
    logic [1:0]  protDis;
    logic        burstDn;
    logic        burstUp;
    logic [1:0]  activity;
    logic        lowPow;
    logic        idLock;
    logic [1:0]  intBusy;
    logic [1:0]  insSync1;
    logic [1:0]  insSync2;
    logic [1:0]  rsvdOe;
    logic [31:0] rdData;
    logic        rdValid;
  } csc_sc_s;

  csc_sc_s    st_reg;
  csc_sc_s    st_next;
  csc_pwr_if  pwr ();
  logic       hit;
  logic [1:0] actClr;
  logic [31:0] rdWord;

  assign pwr.powerReq  = powerReq;
  assign pwr.powerUp   = powerUp;
  assign pwr.powerWord = powerWord;

  csc_power_seq #(
    .BIT_CYC  (BIT_CYC),
    .UP_CYC   (UP_CYC),
    .DOWN_CYC (DOWN_CYC)
  ) u_seq (
    .mclk     (mclk),
    .reset    (reset),
    .pwr      (pwr.seq),
    .pswData  (pswData),
    .pswLatch (pswLatch)
  );

  assign hit = (cfgAddr == csc_pkg::SC_OFFSET);

  always_comb begin
    // Bits outside this block read back at their printed reset value
    rdWord = csc_pkg::SC_RESET_WORD & ~csc_pkg::SC_OWN_MASK;
    rdWord[csc_pkg::B_RSVD_DRIVE] = st_reg.rsvdDrive;
    rdWord[csc_pkg::B_PROT_DIS]   = st_reg.protDis[cfgFunc];
    rdWord[csc_pkg::B_BURST_DN]   = st_reg.burstDn;
    rdWord[csc_pkg::B_BURST_UP]   = st_reg.burstUp;
    rdWord[csc_pkg::B_ACTIVITY]   = st_reg.activity[cfgFunc];
    rdWord[csc_pkg::B_ONE]        = 1'b1;
    rdWord[csc_pkg::B_STREAM]     = pwr.streamBusy;
    rdWord[csc_pkg::B_UP_DLY]     = pwr.upDelayBusy;
    rdWord[csc_pkg::B_DOWN_DLY]   = pwr.downDelayBusy;
    rdWord[csc_pkg::B_INTERROG]   = st_reg.intBusy[cfgFunc];
    rdWord[csc_pkg::B_ZERO]       = 1'b0;
    rdWord[csc_pkg::B_LOW_POW]    = st_reg.lowPow;
    rdWord[csc_pkg::B_ID_LOCK]    = st_reg.idLock;
  end

  always_comb begin
    st_next = st_reg;
    actClr = 2'b00;
    st_next.rdValid = cfgRead;
    st_next.rdData = 32'h0000_0000;
    if (cfgRead && hit) begin
      st_next.rdData = rdWord;
      if (cfgByteEn[1]) begin
        actClr[cfgFunc] = 1'b1;
      end
    end
    // A card access in the clearing cycle survives the read
    st_next.activity = (st_reg.activity & ~actClr) | socketAccess;
    if (cfgWrite && hit) begin
      if (cfgByteEn[2]) begin
        st_next.rsvdDrive = cfgWrData[csc_pkg::B_RSVD_DRIVE];
        st_next.protDis[cfgFunc] = cfgWrData[csc_pkg::B_PROT_DIS];
      end
      // Function 1 writes to global bits 15, 14, 6 and 5 are dropped; bit 22 takes them
      if (cfgByteEn[1] && !cfgFunc) begin
        st_next.burstDn = cfgWrData[csc_pkg::B_BURST_DN];
        st_next.burstUp = cfgWrData[csc_pkg::B_BURST_UP];
      end
      if (cfgByteEn[0] && !cfgFunc) begin
        st_next.lowPow = cfgWrData[csc_pkg::B_LOW_POW];
        st_next.idLock = cfgWrData[csc_pkg::B_ID_LOCK];
      end
    end
    st_next.intBusy = interrogBusy;
    st_next.insSync1 = cardbusInserted;
    st_next.insSync2 = st_reg.insSync1;
    st_next.rsvdOe = st_reg.insSync2 & {2{st_reg.rsvdDrive}};
  end

  // Only the global reset clears this state; no bus reset reaches it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '{rsvdDrive: csc_pkg::RST_RSVD_DRIVE,
                  protDis:   {2{csc_pkg::RST_PROT_DIS}},
                  burstDn:   csc_pkg::RST_BURST_DN,
                  burstUp:   csc_pkg::RST_BURST_UP,
                  lowPow:    csc_pkg::RST_LOW_POW,
                  idLock:    csc_pkg::RST_ID_LOCK,
                  default:   '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfgRdData             = st_reg.rdData;
  assign cfgRdValid            = st_reg.rdValid;
  assign rsvdPinOut            = 2'b00;
  assign rsvdPinOe             = st_reg.rsvdOe;
  assign supplyProtectEn       = ~st_reg.protDis;
  assign readBurstDownstreamEn = st_reg.burstDn;
  assign readBurstUpstreamEn   = st_reg.burstUp;
  assign lowConsumptionEn      = st_reg.lowPow;
  assign idRegistersLock       = st_reg.idLock;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_rd_answer: assert property (cfgRead |=> cfgRdValid)
    else $error("read not answered next cycle");
  a_bit12_one: assert property ((cfgRead && hit) |=> cfgRdData[12])
    else $error("bit 12 did not read one");
  a_bit7_zero: assert property ((cfgRead && hit) |=> !cfgRdData[7])
    else $error("bit 7 did not read zero");
  a_activity_clear: assert property ((cfgRead && hit && cfgByteEn[1] && !cfgFunc
      && !socketAccess[0]) |=> !st_reg.activity[0])
    else $error("activity flag survived its read");
  a_activity_set: assert property (socketAccess[1] |=> st_reg.activity[1])
    else $error("card access lost");
  a_global_fn1: assert property ((cfgWrite && hit && cfgFunc) |=>
      $stable(readBurstDownstreamEn) && $stable(readBurstUpstreamEn)
      && $stable(lowConsumptionEn) && $stable(idRegistersLock))
    else $error("function 1 changed a global bit");
  a_protect_sock: assert property ((cfgWrite && hit && cfgFunc && cfgByteEn[2]
      && cfgWrData[21]) |=> !supplyProtectEn[1] && $stable(supplyProtectEn[0]))
    else $error("per socket protection wrong");
  a_rsvd_drive: assert property ((st_reg.insSync2[0] && st_reg.rsvdDrive)
      |=> rsvdPinOe[0])
    else $error("reserved terminals not driven");
  a_stream_start: assert property ((powerReq && !pwr.streamBusy) |=>
      pwr.streamBusy [*8])
    else $error("stream flag not raised");
  a_delay_excl: assert property ((pwr.upDelayBusy || pwr.downDelayBusy)
      |-> pwr.streamBusy && !(pwr.upDelayBusy && pwr.downDelayBusy))
    else $error("delay flags inconsistent");
  a_interrog_rd: assert property ((cfgRead && hit && !cfgFunc) |=>
      cfgRdData[8] == $past(st_reg.intBusy[0]))
    else $error("interrogation status wrong");
  a_burst_write: assert property ((cfgWrite && hit && !cfgFunc && cfgByteEn[1])
      |=> readBurstDownstreamEn == $past(cfgWrData[15])
      && readBurstUpstreamEn == $past(cfgWrData[14]))
    else $error("burst enable write lost");
  a_ctrl_write: assert property ((cfgWrite && hit && !cfgFunc && cfgByteEn[0])
      |=> lowConsumptionEn == $past(cfgWrData[6])
      && idRegistersLock == $past(cfgWrData[5]))
    else $error("byte 0 control write lost");
  a_unmapped_zero: assert property ((cfgRead && !hit)
      |=> cfgRdData == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_idle: assert property (!cfgRead
      |=> !cfgRdValid && cfgRdData == 32'h0000_0000)
    else $error("read data left standing");
  a_latch_pulse: assert property (pswLatch |->
      (pwr.upDelayBusy || pwr.downDelayBusy) ##1 !pswLatch)
    else $error("latch pulse out of place");
  a_rsvd_release: assert property (rsvdPinOe[1] |->
      $past(st_reg.rsvdDrive) && $past(st_reg.insSync2[1]))
    else $error("reserved terminals driven without cause");

  c_act_read: cover property (socketAccess[0] ##1 (cfgRead && hit && !cfgFunc));
  c_up_delay: cover property ($rose(pwr.upDelayBusy));
  c_down_delay: cover property ($rose(pwr.downDelayBusy));
  c_rsvd_oe: cover property ($rose(rsvdPinOe[1]));
  c_fn1_write: cover property (cfgWrite && hit && cfgFunc);
endmodule

// >>> dv/csc_psw_model.sv
// Power switch model: rebuilds the serial word at each latch pulse.
// Assumes pswData and pswLatch registered on mclk, MSB sent first.
`timescale 1ns/10ps
module csc_psw_model #(
  parameter int BIT_CYC = 4
) (
  input  wire logic       mclk,
  input  wire logic       pswData,
  input  wire logic       pswLatch,
  output logic      [7:0] wordSeen,
  output int              latchCount
);
  logic [8*BIT_CYC-1:0] histReg;
  initial begin
    histReg = '0;
    wordSeen = 8'h00;
    latchCount = 0;
  end
  // Mid-bit sampling, so an edge slip of a cycle still reads true
  always @(posedge mclk) begin
    histReg <= {histReg[8*BIT_CYC-2:0], pswData};
    if (pswLatch === 1'b1) begin
      wordSeen[0] <= pswData;
      for (int j = 1; j < 8; j++) begin
        wordSeen[j] <= histReg[j*BIT_CYC-BIT_CYC/2-1];
      end
      latchCount <= latchCount + 1;
    end
  end
endmodule

// >>> dv/cardbus_system_control_bits_tb.sv
// Bench for the system control bits: config port, power link, pins.
// Assumes the power switch model on the serial outputs.
`timescale 1ns/10ps
module cardbus_system_control_bits_tb;
  localparam int BC = 4;
  localparam int UC = 20;
  localparam int DC = 10;
  logic        mclk, reset, cfgWrite, cfgRead, cfgFunc, cfgRdValid, f;
  logic [7:0]  cfgAddr, powerWord, wordSeen, pw;
  logic [3:0]  cfgByteEn, be;
  logic [31:0] cfgWrData, cfgRdData, rd, o, x;
  logic [1:0]  socketAccess, interrogBusy, cardbusInserted, rsvdPinOut, rsvdPinOe;
  logic [1:0]  supplyProtectEn, e21, act;
  logic        powerReq, powerUp, pswData, pswLatch, rbDn, rbUp, lowCon, idLock;
  logic        e22, e15, e14, e6, e5;
  int          miscompares, tests_run, latchCount, c0, n, seed;

  csc_sysctl #(.BIT_CYC(BC), .UP_CYC(UC), .DOWN_CYC(DC)) DUT (
    .mclk(mclk), .reset(reset), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgFunc(cfgFunc), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .socketAccess(socketAccess), .interrogBusy(interrogBusy),
    .cardbusInserted(cardbusInserted), .powerReq(powerReq), .powerUp(powerUp),
    .powerWord(powerWord), .pswData(pswData), .pswLatch(pswLatch),
    .rsvdPinOut(rsvdPinOut), .rsvdPinOe(rsvdPinOe), .supplyProtectEn(supplyProtectEn),
    .readBurstDownstreamEn(rbDn), .readBurstUpstreamEn(rbUp),
    .lowConsumptionEn(lowCon), .idRegistersLock(idLock));
  csc_psw_model #(.BIT_CYC(BC)) psw (.mclk(mclk), .pswData(pswData),
    .pswLatch(pswLatch), .wordSeen(wordSeen), .latchCount(latchCount));

  always #2.5 mclk = ~mclk;

  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] expWord(input logic fn, input logic [2:0] pb);
    return 32'h0800_1000 | {9'h000, e22, e21[fn], 5'h00, e15, e14, act[fn], 1'b0,
                            pb, interrogBusy[fn], 1'b0, e6, e5, 5'h00};
  endfunction

  task automatic doReset;
    reset = 1'b1;
    {e22, e21, act, e15, e14, e6, e5} = 9'h10B;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    repeat (5) @(negedge mclk);
  endtask

  task automatic cfgWr(input logic fn, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
    @(negedge mclk);
    {cfgWrite, cfgFunc, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, fn, a, b, d};
    @(negedge mclk);
    cfgWrite = 1'b0;
    if (a == 8'h80 && b[2]) {e22, e21[fn]} = d[22:21];
    if (a == 8'h80 && b[1] && !fn) {e15, e14} = d[15:14];
    if (a == 8'h80 && b[0] && !fn) {e6, e5} = d[6:5];
  endtask

  task automatic cfgRd(input logic fn, input logic [7:0] a, input logic [3:0] b);
    @(negedge mclk);
    {cfgRead, cfgFunc, cfgAddr, cfgByteEn} = {1'b1, fn, a, b};
    @(negedge mclk);
    cfgRead = 1'b0;
    chk({31'h0, cfgRdValid}, 32'h1);
    rd = cfgRdData;
  endtask

  task automatic chkOuts;
    o = {22'h0, rsvdPinOe, rsvdPinOut, supplyProtectEn, rbDn, rbUp, lowCon, idLock};
    x = {22'h0, cardbusInserted & {2{e22}}, 2'b00, ~e21, e15, e14, e6, e5};
    chk(o, x);
  endtask

  initial begin
    {mclk, cfgWrite, cfgRead, cfgFunc, cfgAddr, cfgByteEn, cfgWrData} = '0;
    {socketAccess, interrogBusy, cardbusInserted, powerReq, powerUp, powerWord} = '0;
    {miscompares, tests_run} = '0;
    seed = $urandom(954);
    doReset();
    for (int k = 0; k < 3; k++) begin
      if (k == 1) cfgWr(1'b1, 8'h80, 4'hF, 32'hFFFF_FFFF);
      if (k == 2) cfgWr(1'b0, 8'h80, 4'hF, 32'h0000_0000);
      for (int g = 0; g < 2; g++) begin
        cfgRd(g[0], 8'h80, 4'h0);
        chk(rd, expWord(g[0], 3'b000));
      end
      chkOuts();
    end
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      {socketAccess, interrogBusy, cardbusInserted} = 6'($urandom);
      @(negedge mclk);
      act = act | socketAccess;
      socketAccess = 2'b00;
      {f, be} = 5'($urandom);
      cfgWr(f, (i % 4 == 3) ? 8'($urandom) : 8'h80, be, $urandom);
      repeat (4) @(negedge mclk);
      chkOuts();
      be = 4'($urandom);
      cfgRd(f, 8'h80, be);
      chk(rd, expWord(f, 3'b000));
      if (be[1]) act[f] = 1'b0;
      cfgRd(f, 8'h80 ^ 8'($urandom_range(1, 255)), 4'h0);
      chk(rd, 32'h0000_0000);
    end
    for (int k = 0; k < 2; k++) begin
      pw = 8'($urandom);
      c0 = latchCount;
      @(negedge mclk);
      {powerReq, powerUp, powerWord} = {1'b1, k == 0, pw};
      // Held a second cycle with a new word: that request must be dropped
      @(negedge mclk);
      powerWord = ~pw;
      @(negedge mclk);
      powerReq = 1'b0;
      cfgRd(1'b0, 8'h80, 4'h0);
      chk(rd, expWord(1'b0, 3'b100));
      n = 0;
      while (latchCount == c0 && n < 20 * BC) begin
        @(negedge mclk);
        n++;
      end
      // A stream that never latches would stall the rest of the run
      if (latchCount == c0) begin
        miscompares++;
        final_report();
      end
      chk(wordSeen, pw);
      repeat ((k == 0 ? UC : DC) - 5) @(negedge mclk);
      cfgRd(1'b0, 8'h80, 4'h0);
      chk(rd, expWord(1'b0, {1'b1, k == 0, k == 1}));
      n = 0;
      while (rd[11] !== 1'b0 && n < 8) begin
        cfgRd(1'b0, 8'h80, 4'h0);
        n++;
      end
      if (rd[11] !== 1'b0) begin
        miscompares++;
        final_report();
      end
      chk(rd, expWord(1'b0, 3'b000));
    end
    cfgWr(1'b0, 8'h80, 4'hF, 32'h0020_4000);
    doReset();
    cfgRd(1'b1, 8'h80, 4'h0);
    chk(rd, expWord(1'b1, 3'b000));
    chkOuts();
    final_report();
  end
endmodule
